// ===== core/wdtsl_pkg.sv
`default_nettype none
package wdtsl_pkg;

    // I/O space
    localparam int unsigned ADDR_W        = 6;
    localparam int unsigned DATA_W        = 8;
    localparam logic [5:0]  ADDR_CTRL     = 6'h31;
    localparam logic [5:0]  ADDR_CAUSE    = 6'h3B;
    localparam logic [5:0]  ADDR_CCP      = 6'h2F;

    // Protection
    localparam logic [7:0]  CCP_SIGNATURE = 8'hD8;
    localparam logic [2:0]  WINDOW_CYCLES = 3'h4;

    // Control and status field positions
    localparam int unsigned BIT_IF        = 7;
    localparam int unsigned BIT_IE        = 6;
    localparam int unsigned BIT_P3        = 5;
    localparam int unsigned BIT_RSV       = 4;
    localparam int unsigned BIT_WDE       = 3;
    localparam int unsigned BIT_P2        = 2;
    localparam int unsigned BIT_P1        = 1;
    localparam int unsigned BIT_P0        = 0;
    localparam int unsigned BIT_CAUSE     = 3;

    // Reset values
    localparam logic        RST_IF        = 1'b0;
    localparam logic        RST_IE        = 1'b0;
    localparam logic        RST_WDE       = 1'b0;
    localparam logic [3:0]  RST_PER       = 4'h0;
    localparam logic [7:0]  RST_RDATA     = 8'h00;

    // Period select
    localparam logic [3:0]  PER_MAX       = 4'h9;
    localparam int unsigned CNT_W         = 21;
    localparam int unsigned BASE_OSC_CYCLES = 2048;

    // Timing
    localparam int unsigned CLK_HZ        = 50000000;
    localparam int unsigned OSC_HZ        = 128000;
    localparam int unsigned OSC_DIV       = CLK_HZ / OSC_HZ;

    // Time-out behaviour, Gray order along the usual path
    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_IRQ  = 2'b01,
        MODE_BOTH = 2'b11,
        MODE_RST  = 2'b10
    } wdtsl_mode_e;

endpackage : wdtsl_pkg
`default_nettype wire

// ===== core/wdtsl_osc_tick.sv
`timescale 1ns/1ns
`default_nettype none
module wdtsl_osc_tick #(
    parameter int unsigned DIV = wdtsl_pkg::OSC_DIV
) (
    input  wire logic clock,
    input  wire logic arst_n,
    output logic      tick
);
    import wdtsl_pkg::*;

    localparam int unsigned CW   = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] ZERO = CW'(0);
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // Oscillator-rate enable pulse
    assign tick    = (cnt_r == LAST);
    assign cnt_nxt = tick ? ZERO : cnt_r + ONE;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule : wdtsl_osc_tick
`default_nettype wire

// ===== core/wdtsl_top.sv
// Behaviour
// RULE1 - Counter advances on 128 kHz oscillator ticks
// RULE2 - Restart instruction clears the counter
// RULE3 - Disable or device reset clears counter
// RULE4 - Reset-mode time-out resets the system
// RULE5 - Fuse picks safety level one or two
// RULE6 - Level one: enabling needs no protection
// RULE7 - Level one disable needs signature window
// RULE8 - Level two: always running, enable reads one
// RULE9 - Level two period change needs window
// RULE10 - Time-out sets flag; vector clears it
// RULE11 - Writing one clears the interrupt flag
// RULE12 - Mode from enable bits unless fuse programmed
// RULE13 - Combined mode: first time-out interrupts
// RULE14 - Vector clears enable and flag in combined
// RULE15 - Unserviced second time-out resets system
// RULE16 - Software re-arms interrupt enable each time
// RULE17 - Reset-cause flag forces reset-enable high
// RULE18 - Period select gives 2048 to 1048576 cycles
// RULE19 - Reserved bit four reads zero
// RULE20 - Watchdog reset is one-cycle pulse
// RULE21 - Cause flag set on reset, cleared by zero
// RULE22 - Oscillator events safe in system domain
// RULE23 - Protection window closes after four cycles
`timescale 1ns/1ns
`default_nettype none
module wdtsl_top #(
    parameter int unsigned OSC_DIV     = wdtsl_pkg::OSC_DIV,
    parameter int unsigned BASE_CYCLES = wdtsl_pkg::BASE_OSC_CYCLES
) (
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    input  wire logic                          wdog_always_on_fuse,
    input  wire logic [wdtsl_pkg::ADDR_W-1:0]  io_addr,
    input  wire logic [wdtsl_pkg::DATA_W-1:0]  io_wdata,
    input  wire logic                          io_we,
    input  wire logic                          io_re,
    output logic      [wdtsl_pkg::DATA_W-1:0]  io_rdata,
    input  wire logic                          wdr_exec,
    input  wire logic                          irq_vector_ack,
    input  wire logic                          sys_reset_in,
    output logic                               wdog_irq_req,
    output logic                               wdog_sys_reset,
    output logic                               wdog_reset_cause_flag
);
    import wdtsl_pkg::*;

    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [2:0]       WIN_ZERO = 3'h0;
    localparam logic [2:0]       WIN_ONE  = 3'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Period decode

    function automatic logic [CNT_W-1:0] period_last(input logic [3:0] sel);
        logic [CNT_W-1:0] base;
        logic [3:0]       s;
        base = CNT_W'(BASE_CYCLES);
        s    = (sel > PER_MAX) ? PER_MAX : sel;
        return CNT_W'((base << s) - CNT_ONE);
    endfunction : period_last

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic             fuse_loaded_r;
    logic             fuse_r;
    logic             wdog_irq_flag_r;
    logic             wdog_irq_flag_nxt;
    logic             wdog_irq_enable_r;
    logic             wdog_irq_enable_nxt;
    logic             wde_r;
    logic             wde_nxt;
    logic [3:0]       per_r;
    logic [3:0]       per_nxt;
    logic             cause_r;
    logic             cause_nxt;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [2:0]       win_cnt_r;
    logic [2:0]       win_cnt_nxt;
    logic             rst_pulse_r;
    logic [7:0]       rdata_r;
    logic [7:0]       rdata_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator enable

    logic tick;

    wdtsl_osc_tick #(
        .DIV    (OSC_DIV)
    ) u_tick (
        .clock  (clock),
        .arst_n (arst_n),
        .tick   (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Fuse capture after reset release

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fuse_loaded_r <= 1'b0;
            fuse_r        <= 1'b0;
        end else if (!fuse_loaded_r) begin
            fuse_loaded_r <= 1'b1;
            fuse_r        <= wdog_always_on_fuse; // RULE5
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoding

    wire         soft_rst   = rst_pulse_r | sys_reset_in;
    wire         ctrl_wr    = io_we & (io_addr == ADDR_CTRL);
    wire         ccp_wr     = io_we & (io_addr == ADDR_CCP);
    wire         cause_wr   = io_we & (io_addr == ADDR_CAUSE);
    wire         sig_ok     = ccp_wr & (io_wdata == CCP_SIGNATURE);
    wire         win_open   = (win_cnt_r != WIN_ZERO);
    wire         wr_wde     = io_wdata[BIT_WDE];
    wire [3:0]   wr_per     = {io_wdata[BIT_P3], io_wdata[BIT_P2], io_wdata[BIT_P1], io_wdata[BIT_P0]};
    wire         wr_if_clr  = ctrl_wr & io_wdata[BIT_IF]; // RULE11
    wire         wde_eff    = wde_r | cause_r | fuse_r; // RULE8 RULE17

    // Level one: set freely, clear only inside the window
    wire         wde_load   = ctrl_wr & ~fuse_r & (wr_wde | win_open); // RULE6 RULE7
    // Level two: period only inside the window
    wire         per_load   = ctrl_wr & (~fuse_r | win_open); // RULE9

    wdtsl_mode_e mode;
    assign mode = fuse_r ? MODE_RST : wdtsl_mode_e'({wde_eff, wdog_irq_enable_r}); // RULE12

    wire               running   = (mode != MODE_STOP);
    wire [CNT_W-1:0]   cnt_last  = period_last(per_r); // RULE18
    wire               timeout   = tick & running & (count_r >= cnt_last);
    wire               both_mode = (mode == MODE_BOTH);
    wire               timeout_irq = timeout & ((mode == MODE_IRQ) | (both_mode & ~wdog_irq_flag_r)); // RULE13
    wire               timeout_rst = timeout & ((mode == MODE_RST) | (both_mode & wdog_irq_flag_r)); // RULE4 RULE15

    ////////////////////////////////////////////////////////////////////////////
    // Next values

    always_comb begin
        if (soft_rst | wdr_exec | ~running | timeout) begin
            count_nxt = CNT_ZERO; // RULE2 RULE3
        end else if (tick) begin
            count_nxt = count_r + CNT_ONE; // RULE1 RULE22
        end else begin
            count_nxt = count_r;
        end
    end

    always_comb begin
        if (soft_rst) begin
            win_cnt_nxt = WIN_ZERO;
        end else if (sig_ok) begin
            win_cnt_nxt = WINDOW_CYCLES;
        end else if (ctrl_wr) begin
            win_cnt_nxt = WIN_ZERO;
        end else if (win_open) begin
            win_cnt_nxt = win_cnt_r - WIN_ONE; // RULE23
        end else begin
            win_cnt_nxt = win_cnt_r;
        end
    end

    always_comb begin
        if (soft_rst) begin
            wdog_irq_flag_nxt = RST_IF;
        end else if (timeout_irq) begin
            wdog_irq_flag_nxt = 1'b1; // RULE10
        end else if (irq_vector_ack | wr_if_clr) begin
            wdog_irq_flag_nxt = 1'b0; // RULE10 RULE11
        end else begin
            wdog_irq_flag_nxt = wdog_irq_flag_r;
        end
    end

    always_comb begin
        if (soft_rst) begin
            wdog_irq_enable_nxt = RST_IE;
        end else if (irq_vector_ack & both_mode) begin
            wdog_irq_enable_nxt = 1'b0; // RULE14
        end else if (ctrl_wr) begin
            wdog_irq_enable_nxt = io_wdata[BIT_IE];
        end else begin
            wdog_irq_enable_nxt = wdog_irq_enable_r;
        end
    end

    always_comb begin
        if (soft_rst) begin
            wde_nxt = RST_WDE;
        end else if (cause_r) begin
            wde_nxt = 1'b1; // RULE17
        end else if (wde_load) begin
            wde_nxt = wr_wde;
        end else begin
            wde_nxt = wde_r;
        end
    end

    always_comb begin
        if (soft_rst) begin
            per_nxt = RST_PER;
        end else if (per_load) begin
            per_nxt = wr_per;
        end else begin
            per_nxt = per_r;
        end
    end

    always_comb begin
        if (timeout_rst) begin
            cause_nxt = 1'b1; // RULE21
        end else if (cause_wr & ~io_wdata[BIT_CAUSE]) begin
            cause_nxt = 1'b0; // RULE21
        end else begin
            cause_nxt = cause_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        rdata_nxt = RST_RDATA;
        if (io_re && io_addr == ADDR_CTRL) begin
            rdata_nxt[BIT_IF]  = wdog_irq_flag_r;
            rdata_nxt[BIT_IE]  = wdog_irq_enable_r;
            rdata_nxt[BIT_P3]  = per_r[3];
            rdata_nxt[BIT_RSV] = 1'b0; // RULE19
            rdata_nxt[BIT_WDE] = wde_eff; // RULE8
            rdata_nxt[BIT_P2]  = per_r[2];
            rdata_nxt[BIT_P1]  = per_r[1];
            rdata_nxt[BIT_P0]  = per_r[0];
        end else if (io_re && io_addr == ADDR_CAUSE) begin
            rdata_nxt[BIT_CAUSE] = cause_r;
        end else if (!io_re) begin
            rdata_nxt = rdata_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_r   <= CNT_ZERO;
            win_cnt_r <= WIN_ZERO;
            wdog_irq_flag_r    <= RST_IF;
            wdog_irq_enable_r    <= RST_IE;
            wde_r     <= RST_WDE;
            per_r     <= RST_PER;
        end else begin
            count_r   <= count_nxt;
            win_cnt_r <= win_cnt_nxt;
            wdog_irq_flag_r    <= wdog_irq_flag_nxt;
            wdog_irq_enable_r    <= wdog_irq_enable_nxt;
            wde_r     <= wde_nxt;
            per_r     <= per_nxt;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cause_r     <= 1'b0;
            rst_pulse_r <= 1'b0;
            rdata_r     <= RST_RDATA;
        end else begin
            cause_r     <= cause_nxt;
            rst_pulse_r <= timeout_rst; // RULE20
            rdata_r     <= rdata_nxt;
        end
    end

    assign io_rdata              = rdata_r;
    assign wdog_sys_reset        = rst_pulse_r;
    assign wdog_reset_cause_flag = cause_r;
    assign wdog_irq_req          = wdog_irq_flag_r & wdog_irq_enable_r; // RULE10

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock);
    endclocking

    default disable iff (!arst_n);

    sequence s_sig_then_idle;
        sig_ok && !soft_rst ##1 (!ctrl_wr && !sig_ok && !soft_rst) [*4];
    endsequence

    sequence s_first_timeout;
        timeout && both_mode && !wdog_irq_flag_r && !soft_rst;
    endsequence

    a_restart_clears: // RULE2
        assert property (wdr_exec |=> count_r == CNT_ZERO)
        else $error("restart did not clear counter");

    a_stopped_clears: // RULE3
        assert property ((!running || soft_rst) |=> count_r == CNT_ZERO)
        else $error("counter not cleared when stopped or reset");

    a_tick_advances: // RULE1
        assert property (tick && running && !timeout && !soft_rst && !wdr_exec |=> count_r == $past(count_r) + CNT_ONE)
        else $error("counter did not advance on tick");

    a_reset_pulse_once: // RULE20
        assert property (wdog_sys_reset |=> !wdog_sys_reset)
        else $error("watchdog reset longer than one cycle");

    a_timeout_resets: // RULE4
        assert property (timeout && mode == MODE_RST |=> wdog_sys_reset && cause_r)
        else $error("reset-mode time-out gave no reset");

    a_both_irq_first: // RULE13
        assert property (s_first_timeout |=> wdog_irq_flag_r && !wdog_sys_reset)
        else $error("combined mode first time-out misbehaved");

    a_both_unserviced: // RULE15
        assert property (timeout && both_mode && wdog_irq_flag_r |=> wdog_sys_reset)
        else $error("unserviced second time-out gave no reset");

    a_vector_clears: // RULE14
        assert property (irq_vector_ack && both_mode && !timeout && !soft_rst |=> !wdog_irq_flag_r && !wdog_irq_enable_r)
        else $error("vector did not clear flag and enable");

    a_flag_w1c: // RULE11
        assert property (wr_if_clr && !timeout_irq |=> !wdog_irq_flag_r)
        else $error("write one did not clear flag");

    a_flag_zero_keeps: // RULE11
        assert property (ctrl_wr && !io_wdata[BIT_IF] && wdog_irq_flag_r && !irq_vector_ack && !soft_rst |=> wdog_irq_flag_r)
        else $error("write zero changed flag");

    a_level2_wde_one: // RULE8
        assert property (fuse_r && io_re && io_addr == ADDR_CTRL |=> io_rdata[BIT_WDE])
        else $error("level two enable bit not read as one");

    a_reserved_zero: // RULE19
        assert property (io_re && io_addr == ADDR_CTRL |=> !io_rdata[BIT_RSV])
        else $error("reserved bit read as one");

    a_cause_forces: // RULE17
        assert property (cause_r && !soft_rst |=> wde_r)
        else $error("cause flag did not force enable");

    a_level1_guard: // RULE7
        assert property (!fuse_r && wde_r && !cause_r && ctrl_wr && !wr_wde && !win_open && !soft_rst |=> wde_r)
        else $error("unprotected disable accepted");

    a_level2_period: // RULE9
        assert property (fuse_r && ctrl_wr && !win_open && !soft_rst |=> per_r == $past(per_r))
        else $error("unprotected period change accepted");

    a_window_opens: // RULE23
        assert property (sig_ok && !soft_rst |=> win_open)
        else $error("signature did not open window");

    a_window_closes: // RULE23
        assert property (s_sig_then_idle |=> !win_open)
        else $error("window stayed open too long");

    a_period_last: // RULE18
        assert property (per_r <= PER_MAX |-> (cnt_last + CNT_ONE) == (CNT_W'(BASE_CYCLES) << per_r))
        else $error("period decode wrong");

endmodule : wdtsl_top
`default_nettype wire

// ===== test/wdtsl_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module wdtsl_cpu_model (
    input  wire logic                         clock,
    output logic [wdtsl_pkg::ADDR_W-1:0]      io_addr,
    output logic [wdtsl_pkg::DATA_W-1:0]      io_wdata,
    output logic                              io_we,
    output logic                              io_re,
    output logic                              wdr_exec,
    output logic                              irq_vector_ack
);
    import wdtsl_pkg::*;

    // Idle bus before the first request
    initial begin
        io_addr        = '0;
        io_wdata       = '0;
        io_we          = 1'b0;
        io_re          = 1'b0;
        wdr_exec       = 1'b0;
        irq_vector_ack = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Released lines show inverted values
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        io_addr  <= a;
        io_wdata <= d;
        io_we    <= 1'b1;
        @(posedge clock);
        io_we    <= 1'b0;
        io_addr  <= ~a;
        io_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [5:0] a);
        @(posedge clock);
        io_addr <= a;
        io_re   <= 1'b1;
        @(posedge clock);
        io_re   <= 1'b0;
        io_addr <= ~a;
    endtask : rd

    // Restart when which is 0, vector otherwise
    task automatic pulse(input int which);
        @(posedge clock);
        if (which == 0) begin
            wdr_exec <= 1'b1;
        end else begin
            irq_vector_ack <= 1'b1;
        end
        @(posedge clock);
        wdr_exec       <= 1'b0;
        irq_vector_ack <= 1'b0;
    endtask : pulse

    // Signature opening the change window
    task automatic protect;
        wr(ADDR_CCP, CCP_SIGNATURE);
    endtask : protect

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask : idle
endmodule : wdtsl_cpu_model
`default_nettype wire

// ===== test/test_watchdog_timer_with_safety_levels.sv
`timescale 1ns/1ns
`default_nettype none
module test_watchdog_timer_with_safety_levels;
    import wdtsl_pkg::*;
    localparam int DIV   = 4;
    localparam int BASE  = 4;
    localparam int LIMIT = 60000;
    typedef struct {string name; logic [7:0] exp;} wdtsl_note_s;

    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        fuse_lvl = 1'b0;
    logic        sys_rst = 1'b0;
    logic [5:0]  io_addr;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        io_we, io_re, wdr_exec, irq_ack, irq_req, sys_reset, cause;
    logic        rst_prev = 1'b0;
    logic        re_seen = 1'b0;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          rst_cnt = 0;
    wdtsl_note_s notes[$];
    wdtsl_note_s note;

    wdtsl_top #(.OSC_DIV(DIV), .BASE_CYCLES(BASE)) wdtsl_top_i (.clock(clock), .arst_n(arst_n),
        .wdog_always_on_fuse(fuse_lvl), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
        .io_re(io_re), .io_rdata(io_rdata), .wdr_exec(wdr_exec), .irq_vector_ack(irq_ack),
        .sys_reset_in(sys_rst), .wdog_irq_req(irq_req), .wdog_sys_reset(sys_reset),
        .wdog_reset_cause_flag(cause));
    wdtsl_cpu_model wdtsl_cpu_model_i (.clock(clock), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_we(io_we), .io_re(io_re), .wdr_exec(wdr_exec), .irq_vector_ack(irq_ack));

    initial begin
        forever #10 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string name);
        notes.push_back('{name, exp});
        wdtsl_cpu_model_i.rd(a);
    endtask : rd

    task automatic wait_irq(output int n);
        n = 0;
        while (irq_req !== 1'b1 && n < 20000) begin
            @(posedge clock);
            n++;
        end
    endtask : wait_irq

    task automatic wait_rst(input int lim, input logic [7:0] exp);
        int c0;
        int n;
        c0 = rst_cnt;
        n = 0;
        while (rst_cnt == c0 && n < lim) begin
            @(posedge clock);
            n++;
        end
        check("reset_count", 8'(rst_cnt - c0), exp);
    endtask : wait_rst

    ////////////////////////////////////////////////////////////////////////
    // Result watchers
    always @(posedge clock) begin
        re_seen <= io_re & arst_n;
        cycles++;
        if (sys_reset === 1'b1) begin
            rst_cnt++;
            check("reset_width", {7'h00, rst_prev}, 8'h00);
        end
        rst_prev = sys_reset;
        if (cycles == LIMIT) begin
            mismatches++;
            print_verdict();
        end
    end

    always @(negedge clock) begin
        if (re_seen && notes.size() > 0) begin
            note = notes.pop_front();
            check(note.name, io_rdata, note.exp);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        int c0;
        logic [7:0] per;
        void'($urandom(88));
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        rd(ADDR_CTRL, 8'h00, "ctrl_reset");
        rd(ADDR_CAUSE, 8'h00, "cause_reset");
        wdtsl_cpu_model_i.wr(6'h10, 8'($urandom));
        wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h10);
        rd(ADDR_CTRL, 8'h00, "reserved_bit");
        rd(6'h10, 8'h00, "unmapped");
        $display("test reset_state done");

        for (int s = 0; s < 16; s++) begin
            per = {2'b00, s[3], 2'b00, s[2:0]};
            wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'hC0 | per);
            if (s < 10) begin
                wdtsl_cpu_model_i.pulse(0);
                wait_irq(n);
                check("period", {7'h00, n >= (BASE << s) * DIV - DIV && n <= (BASE << s) * DIV + DIV + 2},
                      8'h01);
                wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h40 | per);
                rd(ADDR_CTRL, 8'hC0 | per, "flag_kept");
                wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'hC0 | per);
            end
            rd(ADDR_CTRL, 8'h40 | per, "flag_cleared");
        end
        wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h00);
        wait_rst(200, 8'h00);
        rd(ADDR_CTRL, 8'h00, "stopped");
        $display("test periods done");

        for (int k = 0; k < 2; k++) begin
            c0 = rst_cnt;
            wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h48);
            wdtsl_cpu_model_i.pulse(0);
            wait_irq(n);
            check("irq_before_reset", 8'(rst_cnt - c0), 8'h00);
            if (k == 0) begin
                wdtsl_cpu_model_i.pulse(1);
                rd(ADDR_CTRL, 8'h08, "vector_clears");
                check("irq_line", {7'h00, irq_req}, 8'h00);
            end
            wait_rst(200, 8'h01);
            check("cause_pin", {7'h00, cause}, 8'h01);
            // Long period so the forced reset mode does not fire again
            wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h21);
            rd(ADDR_CTRL, 8'h29, "cause_forces");
            rd(ADDR_CAUSE, 8'h08, "cause_set");
            wdtsl_cpu_model_i.protect();
            wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h21);
            rd(ADDR_CTRL, 8'h29, "cause_holds");
            wdtsl_cpu_model_i.wr(ADDR_CAUSE, 8'h00);
            rd(ADDR_CTRL, 8'h29, "cause_cleared");
            check("cause_pin", {7'h00, cause}, 8'h00);
            wdtsl_cpu_model_i.protect();
            wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h00);
            rd(ADDR_CTRL, 8'h00, "disable_after_cause");
        end
        $display("test combined done");

        wdtsl_cpu_model_i.pulse(0);
        wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h29);
        rd(ADDR_CTRL, 8'h29, "enable_free");
        wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h21);
        rd(ADDR_CTRL, 8'h29, "disable_refused");
        wdtsl_cpu_model_i.protect();
        wdtsl_cpu_model_i.idle(3);
        wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h21);
        rd(ADDR_CTRL, 8'h29, "window_closed");
        wdtsl_cpu_model_i.protect();
        wdtsl_cpu_model_i.idle(2);
        wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h21);
        rd(ADDR_CTRL, 8'h21, "window_last");
        wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h29);
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        rd(ADDR_CTRL, 8'h00, "device_reset");
        $display("test level_one done");

        fuse_lvl <= 1'b1;
        arst_n   <= 1'b0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        rd(ADDR_CTRL, 8'h08, "level2_on");
        wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h01);
        rd(ADDR_CTRL, 8'h08, "level2_locked");
        wdtsl_cpu_model_i.protect();
        wdtsl_cpu_model_i.wr(ADDR_CTRL, 8'h61);
        rd(ADDR_CTRL, 8'h69, "level2_period");
        c0 = rst_cnt;
        repeat (3) begin
            wdtsl_cpu_model_i.idle(6000);
            wdtsl_cpu_model_i.pulse(0);
        end
        check("restart_holds", 8'(rst_cnt - c0), 8'h00);
        wait_rst(8400, 8'h01);
        $display("test level_two done");
        repeat (2) @(posedge clock);
        print_verdict();
    end
endmodule : test_watchdog_timer_with_safety_levels
`default_nettype wire
